// ### verilog/result_regs_pkg.sv
// Constants for the measurement result register bank
package result_regs_pkg;
	localparam logic [7:0] REG_COMP_PRESSURE = 8'h01;
	localparam logic [7:0] REG_COMP_TEMPERATURE = 8'h02;
	localparam logic [7:0] REG_RAW_PRES = 8'h03;
	localparam logic [7:0] REG_RAW_TEMP = 8'h04;
	localparam logic [7:0] REG_UNLOCK_KEY = 8'h05;
	localparam logic [31:0] KEY_SET = 32'h0000_1016;
	localparam logic [31:0] KEY_CLEAR = 32'h0000_0000;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [2:0] WORD_BYTES = 3'h4;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [2:0] SYNC_RESET = 3'h7;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
		ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
	} i2c_state_e;
endpackage

// ### verilog/pin_filter.sv
// Three-flop input synchroniser with agreement filter
module pin_filter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin,
	output logic level
);
	logic [2:0] sync_r;

	// Bus idles high, so reset to the released level
	always_ff @(posedge clk)
	begin
		if (!rstn)
			sync_r <= result_regs_pkg::SYNC_RESET;
		else
			sync_r <= {sync_r[1:0], pin};
	end

	// First flop is never looked at; change counts when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rstn)
			level <= 1'b1;
		else if (sync_r[1] == sync_r[2])
			level <= sync_r[2];
	end
endmodule

// ### verilog/sensor_result_registers.sv
// I2C reached result registers, unlock key and conversion flag
module sensor_result_registers (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [6:0] dev_addr,
	input wire logic auto_mode,
	input wire logic [31:0] refresh_period,
	input wire logic status_wr,
	input wire logic status_wr_data,
	input wire logic meas_valid,
	input wire logic [31:0] meas_comp_pressure,
	input wire logic [31:0] meas_comp_temperature,
	input wire logic [31:0] meas_raw_pressure,
	input wire logic [31:0] meas_raw_temperature,
	output logic update_req,
	output logic conversion_done_flag,
	output logic config_write_enable_flag
);
	logic scl_f, sda_f, scl_d_r, sda_d_r;
	logic start_c, stop_c, rise_c, fall_c;
	result_regs_pkg::i2c_state_e state_r;
	logic [3:0] bit_r;
	logic [2:0] byte_r;
	logic [7:0] rx_r;
	logic [31:0] wdata_r;
	logic [31:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r, mack_r;
	logic key_wr_r;
	logic [31:0] key_data_r;
	logic ld_word_c;
	logic is_result_c;
	logic [31:0] word_c;
	logic [31:0] comp_pressure_r, comp_temperature_r, raw_pres_r, raw_temp_r;
	logic [31:0] tmr_r;

	pin_filter scl_filt (.clk(clk), .rstn(rstn), .pin(scl_in), .level(scl_f));
	pin_filter sda_filt (.clk(clk), .rstn(rstn), .pin(sda_in), .level(sda_f));

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	// Bus edge and condition detection
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	assign start_c = scl_f && scl_d_r && sda_d_r && !sda_f;
	assign stop_c = scl_f && scl_d_r && !sda_d_r && sda_f;
	assign rise_c = scl_f && !scl_d_r;
	assign fall_c = !scl_f && scl_d_r;
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Read word select; unmapped and write-only addresses read as zero
	always_comb
	begin
		case (ptr_r)
			result_regs_pkg::REG_COMP_PRESSURE: word_c = comp_pressure_r;
			result_regs_pkg::REG_COMP_TEMPERATURE: word_c = comp_temperature_r;
			result_regs_pkg::REG_RAW_PRES: word_c = raw_pres_r;
			result_regs_pkg::REG_RAW_TEMP: word_c = raw_temp_r;
			default: word_c = result_regs_pkg::WORD_RESET;
		endcase
	end

	assign is_result_c = (ptr_r >= result_regs_pkg::REG_COMP_PRESSURE)
		&& (ptr_r <= result_regs_pkg::REG_RAW_TEMP);
	// A new word is fetched at the first data byte of each word read
	assign ld_word_c = fall_c && (byte_r == 3'h0)
		&& ((state_r == result_regs_pkg::ST_ACK_ADDR && rw_r)
		|| (state_r == result_regs_pkg::ST_ACK_RD && mack_r));

	////////////////////////////////////////////////////////////////////////
	// Bus slave state machine
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_r <= result_regs_pkg::ST_IDLE;
			bit_r <= 4'h0;
			byte_r <= 3'h0;
			rx_r <= 8'h00;
			wdata_r <= result_regs_pkg::WORD_RESET;
			tx_r <= result_regs_pkg::WORD_RESET;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_n <= 1'b1;
			key_wr_r <= 1'b0;
			key_data_r <= result_regs_pkg::WORD_RESET;
		end
		else
		begin
			key_wr_r <= 1'b0;
			if (start_c)
			begin
				state_r <= result_regs_pkg::ST_ADDR;
				bit_r <= 4'h0;
				byte_r <= 3'h0;
				sda_oe_n <= 1'b1;
			end
			else if (stop_c)
			begin
				state_r <= result_regs_pkg::ST_IDLE;
				sda_oe_n <= 1'b1;
			end
			else
			begin
				case (state_r)
					result_regs_pkg::ST_ADDR, result_regs_pkg::ST_REG:
					begin
						if (rise_c)
						begin
							rx_r <= {rx_r[6:0], sda_f};
							bit_r <= bit_r + 4'h1;
						end
						else if (fall_c && bit_r == result_regs_pkg::BYTE_BITS)
						begin
							bit_r <= 4'h0;
							if (state_r == result_regs_pkg::ST_REG)
							begin
								ptr_r <= rx_r;
								sda_oe_n <= 1'b0;
								state_r <= result_regs_pkg::ST_ACK_REG;
							end
							else if (rx_r[7:1] == dev_addr)
							begin
								rw_r <= rx_r[0];
								sda_oe_n <= 1'b0;
								state_r <= result_regs_pkg::ST_ACK_ADDR;
							end
							else
								state_r <= result_regs_pkg::ST_IDLE;
						end
					end
					result_regs_pkg::ST_ACK_ADDR:
					begin
						if (fall_c && rw_r)
						begin
							tx_r <= word_c;
							sda_oe_n <= word_c[31];
							state_r <= result_regs_pkg::ST_RD;
						end
						else if (fall_c)
						begin
							sda_oe_n <= 1'b1;
							state_r <= result_regs_pkg::ST_REG;
						end
					end
					result_regs_pkg::ST_ACK_REG:
					begin
						if (fall_c)
						begin
							sda_oe_n <= 1'b1;
							byte_r <= 3'h0;
							state_r <= result_regs_pkg::ST_WR;
						end
					end
					result_regs_pkg::ST_WR:
					begin
						if (rise_c)
						begin
							wdata_r <= {wdata_r[30:0], sda_f};
							bit_r <= bit_r + 4'h1;
						end
						else if (fall_c && bit_r == result_regs_pkg::BYTE_BITS)
						begin
							bit_r <= 4'h0;
							byte_r <= byte_r + 3'h1;
							sda_oe_n <= 1'b0;
							state_r <= result_regs_pkg::ST_ACK_WR;
						end
					end
					result_regs_pkg::ST_ACK_WR:
					begin
						if (fall_c)
						begin
							sda_oe_n <= 1'b1;
							state_r <= result_regs_pkg::ST_WR;
							if (byte_r == result_regs_pkg::WORD_BYTES)
							begin
								byte_r <= 3'h0;
								// Writes to result registers are dropped here
								key_wr_r <= (ptr_r == result_regs_pkg::REG_UNLOCK_KEY);
								key_data_r <= wdata_r;
							end
						end
					end
					result_regs_pkg::ST_RD:
					begin
						if (fall_c && bit_r == result_regs_pkg::LAST_BIT)
						begin
							bit_r <= 4'h0;
							sda_oe_n <= 1'b1;
							byte_r <= (byte_r == 3'h3) ? 3'h0 : byte_r + 3'h1;
							state_r <= result_regs_pkg::ST_ACK_RD;
						end
						else if (fall_c)
						begin
							tx_r <= {tx_r[30:0], 1'b0};
							sda_oe_n <= tx_r[30];
							bit_r <= bit_r + 4'h1;
						end
					end
					result_regs_pkg::ST_ACK_RD:
					begin
						if (rise_c)
							mack_r <= !sda_f;
						else if (fall_c && mack_r)
						begin
							// Same register repeats until the host NACKs
							tx_r <= (byte_r == 3'h0) ? word_c : {tx_r[30:0], 1'b0};
							sda_oe_n <= (byte_r == 3'h0) ? word_c[31] : tx_r[30];
							state_r <= result_regs_pkg::ST_RD;
						end
						else if (fall_c)
							state_r <= result_regs_pkg::ST_IDLE;
					end
					default:
						sda_oe_n <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result capture
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			comp_pressure_r <= result_regs_pkg::WORD_RESET;
			comp_temperature_r <= result_regs_pkg::WORD_RESET;
			raw_pres_r <= result_regs_pkg::WORD_RESET;
			raw_temp_r <= result_regs_pkg::WORD_RESET;
		end
		else if (meas_valid)
		begin
			comp_pressure_r <= meas_comp_pressure;
			comp_temperature_r <= meas_comp_temperature;
			raw_pres_r <= meas_raw_pressure;
			raw_temp_r <= meas_raw_temperature;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion flag: a new result beats any clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
			conversion_done_flag <= 1'b0;
		else if (meas_valid)
			conversion_done_flag <= 1'b1;
		else if (status_wr && !status_wr_data)
			conversion_done_flag <= 1'b0;
		else if (ld_word_c && is_result_c && auto_mode)
			conversion_done_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Write-enable flag, changed only by the unlock key
	always_ff @(posedge clk)
	begin
		if (!rstn)
			config_write_enable_flag <= 1'b0;
		else if (key_wr_r && key_data_r == result_regs_pkg::KEY_SET)
			config_write_enable_flag <= 1'b1;
		else if (key_wr_r && key_data_r == result_regs_pkg::KEY_CLEAR)
			config_write_enable_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Update requests: periodic in auto mode, or on host request
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tmr_r <= result_regs_pkg::WORD_RESET;
			update_req <= 1'b0;
		end
		else
		begin
			update_req <= status_wr && status_wr_data;
			if (!auto_mode)
				tmr_r <= result_regs_pkg::WORD_RESET;
			else if (tmr_r >= refresh_period)
			begin
				tmr_r <= result_regs_pkg::WORD_RESET;
				update_req <= 1'b1;
			end
			else
				tmr_r <= tmr_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	pres_load_a: assert property (ld_word_c && ptr_r == result_regs_pkg::REG_COMP_PRESSURE
		|=> tx_r == $past(comp_pressure_r)) else $error("pressure word wrong");
	temp_load_a: assert property (ld_word_c && ptr_r == result_regs_pkg::REG_COMP_TEMPERATURE
		|=> tx_r == $past(comp_temperature_r) && sda_oe_n == $past(comp_temperature_r[31]))
		else $error("temperature word wrong");
	rawp_load_a: assert property (ld_word_c && ptr_r == result_regs_pkg::REG_RAW_PRES
		|=> tx_r == $past(raw_pres_r)) else $error("raw pressure wrong");
	rawt_load_a: assert property (ld_word_c && ptr_r == result_regs_pkg::REG_RAW_TEMP
		|=> tx_r == $past(raw_temp_r)) else $error("raw temperature wrong");
	done_clear_a: assert property (ld_word_c && is_result_c && auto_mode && !meas_valid
		|=> !conversion_done_flag) else $error("flag not cleared");
	key_set_a: assert property (key_wr_r && key_data_r == result_regs_pkg::KEY_SET
		|=> config_write_enable_flag ##1 config_write_enable_flag || key_wr_r)
		else $error("key did not set");
	config_write_enable_flag_cause_a: assert property ($changed(config_write_enable_flag) |-> $past(key_wr_r))
		else $error("enable changed without key");
	key_other_a: assert property (key_wr_r && key_data_r != result_regs_pkg::KEY_SET
		&& key_data_r != result_regs_pkg::KEY_CLEAR |=> $stable(config_write_enable_flag))
		else $error("odd key changed enable");
	key_only_a: assert property (key_wr_r |-> ptr_r == result_regs_pkg::REG_UNLOCK_KEY)
		else $error("write outside key");
	refresh_a: assert property (auto_mode && tmr_r >= refresh_period |=> update_req)
		else $error("no periodic update");
	done_set_a: assert property (meas_valid |=> conversion_done_flag [*1] ##0
		comp_pressure_r == $past(meas_comp_pressure)) else $error("flag not set");
endmodule

// ### bench/i2c_host_model.sv
// Bus host model: byte and register word transfers on the two-wire bus
module i2c_host_model (
	input wire logic clk,
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// Quarter bit time; each clock phase is two of these, above the 8-cycle minimum
	localparam int QTR = 5;
	logic acks_ok;
	logic [7:0] rx_b;
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
		acks_ok = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Also serves as repeated start, so it raises both lines first
	task automatic start_cond;
		sda_drv = 1'b1;
		wt(QTR);
		scl = 1'b1;
		wt(QTR);
		sda_drv = 1'b0;
		wt(QTR);
		scl = 1'b0;
		wt(QTR);
	endtask
	task automatic stop_cond;
		sda_drv = 1'b0;
		wt(QTR);
		scl = 1'b1;
		wt(QTR);
		sda_drv = 1'b1;
		wt(QTR);
	endtask
	// Bit changes only while the clock is low; sampled at the clock's rise
	task automatic xfer_byte(input logic [7:0] tx, input logic nack, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_drv = tx[i];
			wt(QTR);
			scl = 1'b1;
			rx_b[i] = sda;
			wt(2 * QTR);
			scl = 1'b0;
			wt(QTR);
		end
		sda_drv = nack;
		wt(QTR);
		scl = 1'b1;
		ack = ~sda;
		wt(2 * QTR);
		scl = 1'b0;
		wt(QTR);
	endtask
	task automatic send(input logic [7:0] b);
		logic k;
		xfer_byte(b, 1'b1, k);
		acks_ok = acks_ok & k;
	endtask
	// Word goes out most significant byte first
	task automatic write_word(input logic [6:0] a, input logic [7:0] r, input logic [31:0] d);
		acks_ok = 1'b1;
		start_cond();
		send({a, 1'b0});
		send(r);
		for (int i = 3; i >= 0; i--)
			send(d[8 * i +: 8]);
		stop_cond();
	endtask
	// Last byte is refused so the device lets go of the data line before stop
	task automatic read_word(input logic [6:0] a, input logic [7:0] r, output logic [31:0] d);
		logic k;
		acks_ok = 1'b1;
		start_cond();
		send({a, 1'b0});
		send(r);
		start_cond();
		send({a, 1'b1});
		for (int i = 3; i >= 0; i--)
		begin
			xfer_byte(8'hFF, i == 0, k);
			d[8 * i +: 8] = rx_b;
		end
		stop_cond();
	endtask
endmodule

// ### bench/sensor_result_registers_tb_top.sv
// Bench for the result register bank, reached through the bus host model
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
module sensor_result_registers_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic scl, sda_drv, sda_out, sda_oe_n, update_req, done_flag, wen_flag;
	logic auto_mode = 1'b0;
	logic status_wr = 1'b0;
	logic status_wr_data = 1'b0;
	logic meas_valid = 1'b0;
	logic [6:0] dev_addr = 7'h02;
	logic [31:0] refresh_period = 32'h0000_0009;
	logic [31:0] meas[4] = '{32'h3F80_0000, 32'h41C8_0000, 32'h0001_2345, 32'h00AB_CDEF};
	logic [31:0] rd;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Pull-up on the data line: low only while someone pulls it
	wire sda = sda_drv & (sda_oe_n | sda_out);
	always #5 clk = ~clk;
	i2c_host_model host_u (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
	sensor_result_registers dut_u (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .dev_addr(dev_addr), .auto_mode(auto_mode),
		.refresh_period(refresh_period), .status_wr(status_wr), .status_wr_data(status_wr_data),
		.meas_valid(meas_valid), .meas_comp_pressure(meas[0]), .meas_comp_temperature(meas[1]),
		.meas_raw_pressure(meas[2]), .meas_raw_temperature(meas[3]), .update_req(update_req),
		.conversion_done_flag(done_flag), .config_write_enable_flag(wen_flag));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Ceiling well above the roughly 21000 cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse_meas;
		meas_valid = 1'b1;
		tick(1);
		meas_valid = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_results;
		pulse_meas();
		`CHK(done_flag, 1'b1)
		for (int i = 0; i < 4; i++)
		begin
			host_u.read_word(dev_addr, 8'(i + 1), rd);
			`CHK(rd, meas[i])
		end
		`CHK(done_flag, 1'b1)
		host_u.read_word(dev_addr, 8'h05, rd);
		`CHK(rd, 32'h0000_0000)
	endtask
	// Fresh values each time, so a stale word is caught as well
	task automatic t_auto_clear;
		auto_mode = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			meas[i] = ~meas[i];
			pulse_meas();
			`CHK(done_flag, 1'b1)
			host_u.read_word(dev_addr, 8'(i + 1), rd);
			`CHK(rd, meas[i])
			`CHK(done_flag, 1'b0)
		end
		auto_mode = 1'b0;
	endtask
	task automatic t_conversion_done_flag;
		status_wr = 1'b1;
		status_wr_data = 1'b1;
		tick(1);
		status_wr = 1'b0;
		`CHK(update_req, 1'b1)
		tick(1);
		`CHK(update_req, 1'b0)
		pulse_meas();
		status_wr = 1'b1;
		status_wr_data = 1'b0;
		tick(1);
		`CHK(done_flag, 1'b0)
		meas_valid = 1'b1;
		tick(1);
		status_wr = 1'b0;
		meas_valid = 1'b0;
		`CHK(done_flag, 1'b1)
	endtask
	task automatic t_auto_rate;
		int n;
		auto_mode = 1'b1;
		n = 0;
		while (update_req !== 1'b1 && n < 100)
		begin
			tick(1);
			n++;
		end
		`CHK(update_req, 1'b1)
		n = 0;
		do
		begin
			tick(1);
			n++;
		end while (update_req !== 1'b1 && n < 100);
		`CHK(n, 10)
		auto_mode = 1'b0;
		tick(2);
		n = 0;
		repeat (40)
		begin
			tick(1);
			if (update_req === 1'b1)
				n++;
		end
		`CHK(n, 0)
	endtask
	// Entry 4 goes to a foreign address and must be ignored
	task automatic t_key;
		logic [31:0] kv[6] = '{32'h0000_1016, 32'h0000_1234, 32'h0000_0000, 32'h0000_1234,
			32'h0000_1016, 32'h0000_1017};
		logic [5:0] ef = 6'b000011;
		logic [5:0] ea = 6'b101111;
		for (int i = 0; i < 6; i++)
		begin
			host_u.write_word(i == 4 ? dev_addr ^ 7'h01 : dev_addr, 8'h05, kv[i]);
			tick(2);
			`CHK(host_u.acks_ok, ea[i])
			`CHK(wen_flag, ef[i])
		end
		host_u.write_word(dev_addr, 8'h01, 32'hDEAD_BEEF);
		host_u.read_word(dev_addr, 8'h01, rd);
		`CHK(rd, meas[0])
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		tick(6);
		rstn = 1'b1;
		tick(4);
		`CHK(done_flag, 1'b0)
		`CHK(wen_flag, 1'b0)
		t_results();
		t_auto_clear();
		t_conversion_done_flag();
		t_auto_rate();
		t_key();
		print_verdict();
	end
endmodule
